// ===== inc/adcsf_pkg.sv
package adcsf_pkg;
  // converter geometry
  localparam int RES_BITS   = 14;                  // result width
  localparam int FRAME_BITS = 16;                  // serial clocks per frame
  localparam int PAD_BITS   = FRAME_BITS - RES_BITS; // trailing zero bits
  localparam int CNT_BITS   = 5;                   // falling-edge counter width
  localparam int BUF_DEPTH  = 2;                   // result buffer entries

  // serial clock falling-edge marks within a frame
  localparam logic [CNT_BITS-1:0] CONV_END_FALL   = 5'h10; // conversion done
  localparam logic [CNT_BITS-1:0] LONG_FRAME_FALL = 5'h1d; // leaves 16-clock mode
  localparam logic [CNT_BITS-1:0] CNT_MAX         = 5'h1f; // counter saturation

  // sar trial mask for the first bit
  localparam logic [RES_BITS-1:0] SAR_FIRST_MASK = 14'h2000;

  // system clock rate, every pin is sampled at it
  localparam int CLK_FREQ_HZ = 40_000_000;

  // output coding: 1 = differential (two's complement), 0 = single-ended
  localparam logic CODE_DIFF_DEFAULT = 1'b1;

  // frame sequencer states
  typedef enum logic [1:0] {
    st_idle    = 2'b00,  // frame select high, acquiring unless powered down
    st_convert = 2'b01,  // frame active, conversion running
    st_acquire = 2'b10   // frame active, conversion done
  } adcsf_state_t;
endpackage

// ===== inc/adcsf_stream_if.sv
`timescale 1ns/1ps
// valid/ready word channel between converter and result buffer
interface adcsf_stream_if #(
  parameter int WIDTH = 14
);
  logic             valid;  // word offered
  logic             ready;  // consumer can take the word this cycle
  logic [WIDTH-1:0] data;   // word

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// ===== hdl/adcsf_result_buf.sv
`timescale 1ns/1ps
// small fifo holding finished results until the next frame pops one
module adcsf_result_buf
  import adcsf_pkg::*;
#(
  parameter int WIDTH = RES_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // filling and draining sides
  adcsf_stream_if.consumer in_s,
  adcsf_stream_if.producer out_s
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];   // storage
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [PW:0]      count_reg, count_next;
  logic             push, pop;

  // honest flags straight from the occupancy count
  assign in_s.ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data  = mem_reg[rd_ptr_reg];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // pointer wrap helper
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // next state
  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_s.data;
      wr_ptr_next          = bump(wr_ptr_reg);
    end
    if (pop) begin
      rd_ptr_next = bump(rd_ptr_reg);
    end
    // simultaneous push and pop leaves the count alone
    count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      mem_reg    <= mem_next;
    end
  end

  AST_BUF_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    count_reg <= (PW+1)'(DEPTH)) else $error("result buffer over capacity");
endmodule

// ===== hdl/adcsf_frame.sv
`timescale 1ns/1ps
// Operation
// [R1] frame select low means active frame
// [R2] capture input at frame select falling edge
// [R3] frame start drives data pin with msb
// [R4] shift next bit each fall after rise
// [R5] frame shifts previous frame's result
// [R6] conversion on serial clock, ends 16th fall
// [R7] acquisition restarts from 16th falling edge
// [R8] rise before 29th fall keeps 16-clock mode
// [R9] data pin released while frame select high
// [R10] host may end frame after 16th fall
// [R11] channel select low ch0, high ch1
// [R12] host holds channel select around sampling
// [R13] host changes channel between first two rises
// [R14] differential variant codes two's complement
// [R15] single-ended variant codes straight binary
// [R16] host runs serial clock near 40 MHz; the host model runs it at 5 MHz, eight clk periods
// [R17] power-down request sampled at frame end
// [R18] fourteen bits msb first, then zeros
module adcsf_frame
  import adcsf_pkg::*;
#(
  parameter logic CODE_DIFF = CODE_DIFF_DEFAULT
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // serial port from the host
  input  wire logic                frame_sel_n,
  input  wire logic                sclk,
  input  wire logic                input_channel_select,
  input  wire logic                power_down_request,
  // serial data pin, three-state: level and enable
  output logic                     sdo_out,
  output logic                     sdo_oe,
  // offset-binary codes from the analog front end
  input  wire logic [RES_BITS-1:0] sample_ch0,
  input  wire logic [RES_BITS-1:0] sample_ch1,
  // status
  output logic                     acquiring,
  output logic                     converting,
  output logic                     powered_down,
  output logic                     sample_channel,
  output logic                     long_frame
);

  // result channel in and out of the buffer
  adcsf_stream_if #(.WIDTH(RES_BITS)) buf_in ();
  adcsf_stream_if #(.WIDTH(RES_BITS)) buf_out ();

  adcsf_state_t          state_reg, state_next;      // frame sequencer
  logic                  cs_q_reg;                   // last frame select
  logic                  sclk_q_reg;                 // last serial clock
  logic [CNT_BITS-1:0]   fall_cnt_reg, fall_cnt_next; // falls this frame
  logic                  seen_rise_reg, seen_rise_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;      // outgoing word
  logic [RES_BITS-1:0]   held_reg, held_next;        // sampled code
  logic [RES_BITS-1:0]   sar_reg, sar_next;          // trial register
  logic [RES_BITS-1:0]   conv_word_reg, conv_word_next;
  logic                  conv_valid_reg, conv_valid_next;
  logic                  oe_reg, oe_next;
  logic                  chan_reg, chan_next;
  logic                  pd_armed_reg, pd_armed_next;
  logic                  pd_reg, pd_next;
  logic                  long_reg, long_next;

  // pin events, all pins sampled by clk
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic conv_done;

  // output coding of the selected front-end code
  function automatic logic [RES_BITS-1:0] encode(input logic [RES_BITS-1:0] code);
    encode = CODE_DIFF ? {~code[RES_BITS-1], code[RES_BITS-2:0]} : code; // [R14] [R15]
  endfunction

  // edge detection against last cycle's pin levels
  assign cs_fall   = cs_q_reg & ~frame_sel_n;   // [R1]
  assign cs_rise   = ~cs_q_reg & frame_sel_n;   // [R1]
  assign sclk_rise = ~sclk_q_reg & sclk & ~frame_sel_n;
  assign sclk_fall = sclk_q_reg & ~sclk & ~frame_sel_n;
  // the 16th fall of an active frame ends conversion
  assign conv_done = (state_reg == st_convert) && sclk_fall
                     && (fall_cnt_reg == CONV_END_FALL - 5'h01);

  // buffer hookup: pop exactly at frame start
  assign buf_in.valid  = conv_valid_reg;
  assign buf_in.data   = conv_word_reg;
  assign buf_out.ready = cs_fall;

  adcsf_result_buf #(
    .WIDTH (RES_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (buf_in),
    .out_s (buf_out)
  );

  // frame sequencer, counter, shifter and converter
  always_comb begin
    state_next      = state_reg;
    fall_cnt_next   = fall_cnt_reg;
    seen_rise_next  = seen_rise_reg;
    shift_next      = shift_reg;
    held_next       = held_reg;
    sar_next        = sar_reg;
    conv_word_next  = conv_word_reg;
    conv_valid_next = conv_valid_reg;
    chan_next       = chan_reg;
    // a word handed to the buffer is done
    if (buf_in.valid && buf_in.ready) begin
      conv_valid_next = 1'b0;
    end
    unique case (state_reg)
      st_idle: begin
        if (cs_fall) begin
          state_next     = st_convert;
          fall_cnt_next  = '0;
          seen_rise_next = 1'b0;
          sar_next       = '0;
          // sample the selected channel, end of acquisition
          chan_next      = input_channel_select;                                   // [R11]
          held_next      = encode(input_channel_select ? sample_ch1 : sample_ch0); // [R2]
          // previous frame's result, empty buffer shifts zeros
          shift_next     = buf_out.valid ? {buf_out.data, PAD_BITS'(0)} : '0;     // [R3] [R5] [R18]
        end
      end
      st_convert, st_acquire: begin
        if (sclk_rise) begin
          seen_rise_next = 1'b1;
        end
        if (sclk_fall) begin
          if (fall_cnt_reg != CNT_MAX) begin
            fall_cnt_next = fall_cnt_reg + 5'h01;
          end
          // no shifting until a rise has been seen
          if (seen_rise_reg) begin
            shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0}; // [R4] [R18]
          end
        end
        // one trial bit per fall over the first 14 falls, msb first
        if (state_reg == st_convert && sclk_fall) begin
          sar_next = sar_reg | (held_reg & (SAR_FIRST_MASK >> fall_cnt_reg)); // [R6]
        end
        if (conv_done) begin
          // result leaves for the buffer; a still pending word keeps its
          // place, which cannot occur while each frame pops one
          state_next = st_acquire;                                   // [R7]
          if (!conv_valid_reg || buf_in.ready) begin
            conv_word_next  = sar_reg | (held_reg & (SAR_FIRST_MASK >> fall_cnt_reg)); // [R6]
            conv_valid_next = 1'b1;
          end
        end
        // host may stop sclk after the 16th fall and raise select later
        if (cs_rise) begin
          state_next = st_idle; // [R10]
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  // pin and power-down state
  always_comb begin
    oe_next       = ~frame_sel_n; // [R9]
    pd_armed_next = pd_armed_reg;
    pd_next       = pd_reg;
    long_next     = long_reg;
    // power-down enable looks at the request only at frame end
    if (cs_rise) begin
      pd_armed_next = power_down_request; // [R17]
      if (!power_down_request) begin
        pd_next = 1'b0;
      end
    end
    // sleep right after conversion when armed
    if (conv_done && pd_armed_reg) begin
      pd_next = 1'b1;
    end
    // 29 falls in one frame leaves 16-clock operation
    if (cs_fall) begin
      long_next = 1'b0;
    end else if (state_reg != st_idle && sclk_fall
                 && fall_cnt_reg == LONG_FRAME_FALL - 5'h01) begin
      long_next = 1'b1; // [R8]
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= st_idle;
      cs_q_reg       <= 1'b1;
      sclk_q_reg     <= 1'b0;
      fall_cnt_reg   <= '0;
      seen_rise_reg  <= 1'b0;
      shift_reg      <= '0;
      held_reg       <= '0;
      sar_reg        <= '0;
      conv_word_reg  <= '0;
      conv_valid_reg <= 1'b0;
      oe_reg         <= 1'b0;
      chan_reg       <= 1'b0;
      pd_armed_reg   <= 1'b0;
      pd_reg         <= 1'b0;
      long_reg       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cs_q_reg       <= frame_sel_n;
      sclk_q_reg     <= sclk;
      fall_cnt_reg   <= fall_cnt_next;
      seen_rise_reg  <= seen_rise_next;
      shift_reg      <= shift_next;
      held_reg       <= held_next;
      sar_reg        <= sar_next;
      conv_word_reg  <= conv_word_next;
      conv_valid_reg <= conv_valid_next;
      oe_reg         <= oe_next;
      chan_reg       <= chan_next;
      pd_armed_reg   <= pd_armed_next;
      pd_reg         <= pd_next;
      long_reg       <= long_next;
    end
  end

  // outputs, all from flops except the converting and acquiring decodes
  assign sdo_out        = shift_reg[FRAME_BITS-1];
  assign sdo_oe         = oe_reg;
  assign converting     = (state_reg == st_convert);
  assign acquiring      = (state_reg != st_convert) && !pd_reg; // [R7]
  assign powered_down   = pd_reg;
  assign sample_channel = chan_reg;
  assign long_frame     = long_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_HIZ_IDLE: assert property ( // [R9]
    frame_sel_n |=> !sdo_oe) else $error("data pin driven while idle");

  AST_MSB_AT_START: assert property ( // [R3]
    cs_fall |=> sdo_oe && (sdo_out == ($past(buf_out.valid) && $past(buf_out.data[RES_BITS-1]))))
    else $error("msb not presented at frame start");

  AST_CAPTURE: assert property ( // [R2]
    cs_fall |=> held_reg == encode($past(input_channel_select) ? $past(sample_ch1) : $past(sample_ch0))
      && sample_channel == $past(input_channel_select)) else $error("wrong sample captured");

  AST_HOLD_BEFORE_RISE: assert property ( // [R4]
    (state_reg != st_idle) && !seen_rise_reg && sclk_fall && !cs_rise |=> $stable(shift_reg))
    else $error("shifted before first rise");

  AST_SHIFT_FALL: assert property ( // [R4]
    (state_reg != st_idle) && seen_rise_reg && sclk_fall && !cs_rise
      |=> shift_reg == {$past(shift_reg[FRAME_BITS-2:0]), 1'b0}) else $error("bad shift");

  AST_PREV_RESULT: assert property ( // [R5]
    cs_fall && buf_out.valid |=> shift_reg == {$past(buf_out.data), PAD_BITS'(0)})
    else $error("frame does not carry previous result");

  AST_CONV_END: assert property ( // [R6]
    conv_done && !cs_rise |=> state_reg == st_acquire ##0 conv_valid_reg
      ##0 conv_word_reg == $past(held_reg)) else $error("conversion not finished at 16th fall");

  AST_ACQ_AFTER_END: assert property ( // [R7]
    conv_done && !pd_armed_reg |=> acquiring [*1] ##1 (acquiring || cs_fall || !rst_n))
    else $error("acquisition not restarted");

  AST_STAY_16: assert property ( // [R8]
    (state_reg != st_idle) && fall_cnt_reg < LONG_FRAME_FALL && !cs_fall |-> !long_frame)
    else $error("long frame flagged early");

  AST_PD_LATCH: assert property ( // [R17]
    cs_rise |=> pd_armed_reg == $past(power_down_request)) else $error("power-down request not latched");

  AST_RESULT_ZEROS: assert property ( // [R18]
    state_reg == st_acquire && seen_rise_reg |-> fall_cnt_reg < CONV_END_FALL || !sdo_out)
    else $error("pad bits not zero");

  COV_FRAME_DONE: cover property (conv_done ##[1:400] cs_rise);
  COV_BACK_TO_BACK: cover property (cs_fall && buf_out.valid ##[1:800] cs_fall && buf_out.valid);
  COV_POWER_DOWN: cover property (pd_reg ##1 cs_rise);
  COV_LONG_FRAME: cover property ($rose(long_reg));
endmodule

// ===== sim/adcsf_host.sv
`timescale 1ns/1ps
// host model: serial master for the frame port, sclk idles low outside frames unless park_high raises it
module adcsf_host
  import adcsf_pkg::*;
(
  // clock
  input  wire logic       clk,
  // observed pins
  input  wire logic [1:0] sdo_wire,
  input  wire logic [3:0] stat,
  // driven pins
  output logic            frame_sel_n,
  output logic            sclk,
  output logic            input_channel_select,
  output logic            power_down_request
);
  initial begin
    frame_sel_n          = 1'b1; // idle between frames
    sclk                 = 1'b0;
    input_channel_select = 1'b0;
    power_down_request   = 1'b0;
  end

  // step off the sampling edge by a fixed small delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // park sclk high between frames, so the next frame opens with a fall
  task automatic park_high;
    tick(1);
    sclk = 1'b1;
  endtask

  // one frame of n falls; data captured on each of the first 16 sclk rises, as a master does
  task automatic frame(input int n, input logic nch, input logic pd, output logic [15:0] d0,
                       output logic [15:0] d1, output logic [3:0] mid, output logic [3:0] fin);
    d0 = 16'h0000;
    d1 = 16'h0000;
    tick(1);
    frame_sel_n = 1'b0;
    tick(3);
    mid = stat;
    for (int i = 0; i < n; i++) begin
      // half period of four clocks: a port sampled at clk cannot follow sclk at clk rate
      sclk = 1'b1;
      if (i < FRAME_BITS) begin
        d0[15-i] = sdo_wire[0];
        d1[15-i] = sdo_wire[1];
      end
      tick(4);
      sclk = 1'b0;
      // next channel chosen between first and second rise
      if (i == 0) begin
        input_channel_select = nch;
      end
      tick(4);
    end
    fin = stat;
    power_down_request = pd;
    tick(1);
    frame_sel_n = 1'b1;
    tick(4);
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import adcsf_pkg::*;
  localparam logic [13:0] VA = 14'h2001; // msb set
  localparam logic [13:0] VB = 14'h1ffe; // msb clear
  localparam logic [13:0] VC = 14'h3fff; // full scale
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [RES_BITS-1:0] s0 = VA;
  logic [RES_BITS-1:0] s1 = VB;
  logic                fsn, sck, chs, pdr;
  logic [1:0]          sdo_out, sdo_oe, last = 2'b00;
  wire logic [1:0]     sdo_wire;
  logic                acq, conv, pdn, chan, lng;
  int                  miscompares = 0;
  int                  compares = 0;

  always #12.5 clk = ~clk;

  // released pin shows the inverse of its last level
  always @(posedge clk) last <= sdo_wire;
  assign sdo_wire = (sdo_oe & sdo_out) | (~sdo_oe & ~last);

  adcsf_frame #(.CODE_DIFF(1'b1)) dut (.clk(clk), .rst_n(rst_n), .frame_sel_n(fsn), .sclk(sck),
    .input_channel_select(chs), .power_down_request(pdr), .sdo_out(sdo_out[0]), .sdo_oe(sdo_oe[0]),
    .sample_ch0(s0), .sample_ch1(s1), .acquiring(acq), .converting(conv), .powered_down(pdn),
    .sample_channel(chan), .long_frame(lng));
  // single-ended variant shares every input
  adcsf_frame #(.CODE_DIFF(1'b0)) dut_se (.clk(clk), .rst_n(rst_n), .frame_sel_n(fsn), .sclk(sck),
    .input_channel_select(chs), .power_down_request(pdr), .sdo_out(sdo_out[1]), .sdo_oe(sdo_oe[1]),
    .sample_ch0(s0), .sample_ch1(s1), .acquiring(), .converting(), .powered_down(),
    .sample_channel(), .long_frame());

  adcsf_host host (.clk(clk), .sdo_wire(sdo_wire), .stat({pdn, conv, acq, sdo_oe[0]}),
    .frame_sel_n(fsn), .sclk(sck), .input_channel_select(chs), .power_down_request(pdr));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // frame word: 14 bits msb first, two zero pads
  function automatic logic [15:0] word(input logic [13:0] c, input logic diff);
    return {diff ? {~c[13], c[12:0]} : c, 2'b00};
  endfunction

  task automatic frame_chk(input int n, input logic nch, input logic pd, input logic dchk,
                           input logic [15:0] e0, input logic [15:0] e1, input logic [3:0] emid,
                           input logic [3:0] efin);
    logic [15:0] d0, d1;
    logic [3:0]  mid, fin;
    host.frame(n, nch, pd, d0, d1, mid, fin);
    if (dchk) begin
      check("sdo diff", e0, d0);
      check("sdo single", e1, d1);
    end
    check("status mid", 16'(emid), 16'(mid));
    check("status end", 16'(efin), 16'(fin));
    check("oe idle", 16'h0000, 16'(sdo_oe));
  endtask

  task automatic t_reset;
    check("oe reset", 16'h0000, 16'(sdo_oe));
    check("status reset", 16'h0002, 16'({pdn, conv, acq, lng}));
    $display("test reset done");
  endtask

  // results trail the sample by one frame; channels alternate
  task automatic t_stream;
    frame_chk(16, 1'b1, 1'b0, 1'b1, 16'h0000, 16'h0000, 4'h5, 4'h3);
    check("channel", 16'h0000, 16'(chan));
    frame_chk(16, 1'b0, 1'b0, 1'b1, word(VA, 1'b1), word(VA, 1'b0), 4'h5, 4'h3);
    check("channel", 16'h0001, 16'(chan));
    s0 = VC;
    frame_chk(16, 1'b1, 1'b0, 1'b1, word(VB, 1'b1), word(VB, 1'b0), 4'h5, 4'h3);
    check("channel", 16'h0000, 16'(chan));
    frame_chk(16, 1'b1, 1'b0, 1'b1, word(VC, 1'b1), word(VC, 1'b0), 4'h5, 4'h3);
    check("channel", 16'h0001, 16'(chan));
    $display("test stream done");
  endtask

  // request at one rise takes effect after the next conversion; data still flows
  task automatic t_powerdown;
    frame_chk(16, 1'b1, 1'b1, 1'b1, word(VB, 1'b1), word(VB, 1'b0), 4'h5, 4'h3);
    frame_chk(16, 1'b1, 1'b0, 1'b1, word(VB, 1'b1), word(VB, 1'b0), 4'h5, 4'h9);
    check("power down clear", 16'h0000, 16'(pdn));
    $display("test powerdown done");
  endtask

  // 28 falls stays in 16-clock mode, 29 leaves it
  task automatic t_long;
    frame_chk(28, 1'b1, 1'b0, 1'b1, word(VB, 1'b1), word(VB, 1'b0), 4'h5, 4'h3);
    check("long 28", 16'h0000, 16'(lng));
    frame_chk(29, 1'b1, 1'b0, 1'b1, word(VB, 1'b1), word(VB, 1'b0), 4'h5, 4'h3);
    check("long 29", 16'h0001, 16'(lng));
    $display("test long done");
  endtask

  // sclk parked high: the first fall comes before any rise and must not shift,
  // yet it still counts toward the 16th fall that ends conversion
  task automatic t_early_fall;
    logic [15:0] w0, w1;
    w0 = word(VB, 1'b1);
    w1 = word(VB, 1'b0);
    host.park_high();
    frame_chk(16, 1'b1, 1'b0, 1'b1, {w0[15], w0[15:1]}, {w1[15], w1[15:1]}, 4'h5, 4'h3);
    $display("test early fall done");
  endtask

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #(25 * 20000);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    t_reset();
    t_stream();
    t_powerdown();
    t_long();
    t_early_fall();
    final_report();
  end
endmodule
